// *** design/pcg_gate_cell.sv ***
// one gated clock-enable lane with bus isolation for one peripheral
`timescale 1ns/1ps
module pcg_gate_cell (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // control
  input wire logic tick,
  input wire logic gate_off,
  input wire logic present,
  // to the peripheral
  output logic clk_en,
  output logic bus_en
);

  // enabled only when bit is clear and the peripheral exists; change lands on the
  // next instruction tick, so the switch comes within one instruction cycle of the write
  logic want;
  assign want = ~gate_off & present;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clk_en <= 1'b0;
      bus_en <= 1'b0;
    end else if (tick) begin
      clk_en <= want;
      bus_en <= want;
    end
  end

endmodule : pcg_gate_cell

// *** design/pcg_peripheral_clock_gating.sv ***
// peripheral clock gating: three disable registers over Avalon-MM, per-module enables
`timescale 1ns/1ps
module pcg_peripheral_clock_gating
  import pcg_pkg::*;
#(
  parameter logic [15:0] PRESENT_ONE = 16'hF9FB,
  parameter logic [15:0] PRESENT_TWO = 16'hC30F,
  parameter logic [15:0] PRESENT_THREE = 16'h07C0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [PCG_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // per-module clock enables (one lane per control bit)
  output logic [15:0] clk_en_one,
  output logic [15:0] clk_en_two,
  output logic [15:0] clk_en_three,
  // per-module register-bus enables
  output logic [15:0] bus_en_one,
  output logic [15:0] bus_en_two,
  output logic [15:0] bus_en_three
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  initial begin
    if ((PRESENT_ONE & ~PCG_MASK_ONE) != 16'h0000 || (PRESENT_TWO & ~PCG_MASK_TWO) != 16'h0000 ||
        (PRESENT_THREE & ~PCG_MASK_THREE) != 16'h0000) begin
      $error("pcg: present mask names an unimplemented bit");
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] peripheral_gate_ctrl_one_ff;
  logic [15:0] peripheral_gate_ctrl_two_ff;
  logic [15:0] peripheral_gate_ctrl_three_ff;
  logic [7:0] tick_div_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic tick;

  // decoded request, word index from the byte address
  logic [3:0] idx;
  logic req;
  logic wr_go;
  logic rd_go;
  logic [15:0] be_mask;
  logic [15:0] nxt_one;
  logic [15:0] nxt_two;
  logic [15:0] nxt_three;
  logic [31:0] nxt_rdata;

  assign idx = avs_address[PCG_ADDR_W-1:2];
  assign req = (avs_read | avs_write) & ~ack_ff;
  // a write lands in the answer cycle, at the edge where the master sees waitrequest low
  assign wr_go = avs_write & ack_ff;
  assign rd_go = avs_read & ~ack_ff;
  assign be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // merge write data under byte enables, dropping unimplemented positions
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [15:0] be, input logic [15:0] mask);
    merge = ((old & ~be) | (wd & be)) & mask;
  endfunction : merge

  always_comb begin
    nxt_one = peripheral_gate_ctrl_one_ff;
    nxt_two = peripheral_gate_ctrl_two_ff;
    nxt_three = peripheral_gate_ctrl_three_ff;
    if (wr_go) begin
      case (idx)
        PCG_IDX_CTRL_ONE: begin
          nxt_one = merge(peripheral_gate_ctrl_one_ff, avs_writedata[15:0], be_mask, PCG_MASK_ONE);
        end
        PCG_IDX_CTRL_TWO: begin
          nxt_two = merge(peripheral_gate_ctrl_two_ff, avs_writedata[15:0], be_mask, PCG_MASK_TWO);
        end
        PCG_IDX_CTRL_THREE: begin
          nxt_three = merge(peripheral_gate_ctrl_three_ff, avs_writedata[15:0], be_mask, PCG_MASK_THREE);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      peripheral_gate_ctrl_one_ff <= PCG_CTRL_RST;
      peripheral_gate_ctrl_two_ff <= PCG_CTRL_RST;
      peripheral_gate_ctrl_three_ff <= PCG_CTRL_RST;
    end else begin
      peripheral_gate_ctrl_one_ff <= nxt_one;
      peripheral_gate_ctrl_two_ff <= nxt_two;
      peripheral_gate_ctrl_three_ff <= nxt_three;
    end
  end

  // divider reload; zero means every clock is an instruction cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tick_div_ff <= PCG_TICK_DIV_RST;
    end else if (wr_go && idx == PCG_IDX_TICK_DIV && avs_byteenable[0]) begin
      tick_div_ff <= avs_writedata[7:0];
    end
  end

  // ****************************************************************
  // gating lanes
  // ****************************************************************
  pcg_tick_div #(
    .CNT_W(8)
  ) u_tick (
    .clk_sys(clk_sys),
    .srst(srst),
    .div(tick_div_ff),
    .tick(tick)
  );

  logic [47:0] gate_off_all;
  logic [47:0] present_all;
  logic [47:0] clk_en_all;
  logic [47:0] bus_en_all;

  // a one in a control bit means off, a zero means on
  assign gate_off_all = {peripheral_gate_ctrl_three_ff, peripheral_gate_ctrl_two_ff,
                         peripheral_gate_ctrl_one_ff};
  assign present_all = {PRESENT_THREE, PRESENT_TWO, PRESENT_ONE};

  for (genvar g = 0; g < 48; g++) begin : g_lane
    pcg_gate_cell u_cell (
      .clk_sys(clk_sys),
      .srst(srst),
      .tick(tick),
      .gate_off(gate_off_all[g]),
      .present(present_all[g]),
      .clk_en(clk_en_all[g]),
      .bus_en(bus_en_all[g])
    );
  end

  // lanes already come from flip-flops inside the cells
  assign clk_en_one = clk_en_all[15:0];
  assign clk_en_two = clk_en_all[31:16];
  assign clk_en_three = clk_en_all[47:32];
  assign bus_en_one = bus_en_all[15:0];
  assign bus_en_two = bus_en_all[31:16];
  assign bus_en_three = bus_en_all[47:32];

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (idx)
      PCG_IDX_CTRL_ONE: begin
        nxt_rdata = {16'h0000, peripheral_gate_ctrl_one_ff & PCG_MASK_ONE};
      end
      PCG_IDX_CTRL_TWO: begin
        nxt_rdata = {16'h0000, peripheral_gate_ctrl_two_ff & PCG_MASK_TWO};
      end
      PCG_IDX_CTRL_THREE: begin
        nxt_rdata = {16'h0000, peripheral_gate_ctrl_three_ff & PCG_MASK_THREE};
      end
      PCG_IDX_PRESENT_ONE: begin
        nxt_rdata = {16'h0000, PRESENT_ONE};
      end
      PCG_IDX_PRESENT_TWO: begin
        nxt_rdata = {16'h0000, PRESENT_TWO};
      end
      PCG_IDX_PRESENT_THREE: begin
        nxt_rdata = {16'h0000, PRESENT_THREE};
      end
      PCG_IDX_ENABLED_ONE: begin
        nxt_rdata = {16'h0000, clk_en_all[15:0]};
      end
      PCG_IDX_ENABLED_TWO: begin
        nxt_rdata = {16'h0000, clk_en_all[31:16]};
      end
      PCG_IDX_ENABLED_THREE: begin
        nxt_rdata = {16'h0000, clk_en_all[47:32]};
      end
      PCG_IDX_TICK_DIV: begin
        nxt_rdata = {24'h000000, tick_div_ff};
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  // ****************************************************************
  // avalon handshake: one wait state, every access answered
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_go) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // waitrequest high by default, dropped for exactly the answer cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~req;
    end
  end

  assign avs_readdata = rdata_ff;

endmodule : pcg_peripheral_clock_gating

// *** design/pcg_pkg.sv ***
// package for the peripheral clock gating block: offsets, masks, reset values, timing
package pcg_pkg;

  // ****************************************************************
  // register map (word offsets, byte address = 4 * index)
  // ****************************************************************
  localparam logic [3:0] PCG_IDX_CTRL_ONE = 4'h0;
  localparam logic [3:0] PCG_IDX_CTRL_TWO = 4'h1;
  localparam logic [3:0] PCG_IDX_CTRL_THREE = 4'h2;
  localparam logic [3:0] PCG_IDX_PRESENT_ONE = 4'h3;
  localparam logic [3:0] PCG_IDX_PRESENT_TWO = 4'h4;
  localparam logic [3:0] PCG_IDX_PRESENT_THREE = 4'h5;
  localparam logic [3:0] PCG_IDX_ENABLED_ONE = 4'h6;
  localparam logic [3:0] PCG_IDX_ENABLED_TWO = 4'h7;
  localparam logic [3:0] PCG_IDX_ENABLED_THREE = 4'h8;
  localparam logic [3:0] PCG_IDX_TICK_DIV = 4'h9;
  localparam int PCG_ADDR_W = 6;

  // ****************************************************************
  // implemented bit masks of the three control registers
  // ****************************************************************
  localparam logic [15:0] PCG_MASK_ONE = 16'hF9FB;
  localparam logic [15:0] PCG_MASK_TWO = 16'hC30F;
  localparam logic [15:0] PCG_MASK_THREE = 16'h07C0;
  localparam logic [15:0] PCG_CTRL_RST = 16'h0000;

  // field positions, first control register
  localparam int PCG_B1_TIMER5 = 15;
  localparam int PCG_B1_TIMER1 = 11;
  localparam int PCG_B1_CODEC = 8;
  localparam int PCG_B1_TWO_WIRE = 7;
  localparam int PCG_B1_UART_B = 6;
  localparam int PCG_B1_UART_A = 5;
  localparam int PCG_B1_SPI_B = 4;
  localparam int PCG_B1_SPI_A = 3;
  localparam int PCG_B1_CAN = 1;
  localparam int PCG_B1_ADC = 0;
  // second control register
  localparam int PCG_B2_CAPTURE8 = 15;
  localparam int PCG_B2_CAPTURE7 = 14;
  localparam int PCG_B2_CAPTURE2 = 9;
  localparam int PCG_B2_CAPTURE1 = 8;
  localparam int PCG_B2_COMPARE4 = 3;
  localparam int PCG_B2_COMPARE1 = 0;
  // third control register
  localparam int PCG_B3_COMPARATOR = 10;
  localparam int PCG_B3_CALENDAR = 9;
  localparam int PCG_B3_PARALLEL = 8;
  localparam int PCG_B3_CHECKSUM = 7;
  localparam int PCG_B3_DAC = 6;

  // ****************************************************************
  // timing: instruction cycle derived from the system clock
  // ****************************************************************
  localparam int PCG_CLK_MHZ = 200;
  localparam int PCG_INSTR_NS = 25;
  localparam int PCG_INSTR_CYC = (PCG_INSTR_NS * PCG_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] PCG_TICK_DIV_RST = 8'(PCG_INSTR_CYC - 1);

endpackage : pcg_pkg

// *** design/pcg_tick_div.sv ***
// instruction-cycle tick divider: one-cycle enable pulse every div+1 clocks
`timescale 1ns/1ps
module pcg_tick_div
  import pcg_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // control
  input wire logic [CNT_W-1:0] div,
  // tick out
  output logic tick
);

  initial begin
    if (CNT_W < 1 || CNT_W > 16) begin
      $error("pcg_tick_div: CNT_W out of range");
    end
  end

  logic [CNT_W-1:0] cnt_ff;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_ff <= '0;
      tick <= 1'b0;
    end else if (cnt_ff >= div) begin
      cnt_ff <= '0;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule : pcg_tick_div

// *** verif/pcg_peripheral_clock_gating_bench.sv ***
// self-checking bench for the peripheral clock gating block
`timescale 1ns/1ps
module pcg_peripheral_clock_gating_bench;
  import pcg_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] clk_en_one, clk_en_two, clk_en_three, bus_en_one, bus_en_two, bus_en_three;
  logic [31:0] rd;
  logic [15:0] msk [3] = '{PCG_MASK_ONE, PCG_MASK_TWO, PCG_MASK_THREE};
  logic [15:0] e [3];
  int fail_count = 0;
  int checks = 0;
  pcg_peripheral_clock_gating DUT (
    .clk_sys(clk_sys),
    .srst(srst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .clk_en_one(clk_en_one),
    .clk_en_two(clk_en_two),
    .clk_en_three(clk_en_three),
    .bus_en_one(bus_en_one),
    .bus_en_two(bus_en_two),
    .bus_en_three(bus_en_three)
  );
  always #2.5 clk_sys = ~clk_sys;
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // each bus task starts one edge late so a strobe never rises in the edge that dropped it
  task av_wr(input logic [5:0] a, input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do begin @(posedge clk_sys); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) chk("write answer", 1, 0);
    avs_write <= 1'b0;
  endtask : av_wr
  task av_rd(input logic [5:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    do begin @(posedge clk_sys); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) chk("read answer", 1, 0);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask : av_rd
  // lanes follow on the next instruction tick, so seven clocks always suffice
  task lanes(input logic [15:0] e1, input logic [15:0] e2, input logic [15:0] e3);
    repeat (7) @(posedge clk_sys);
    chk("clk_en", 48'({e1, e2, e3}) , 48'({clk_en_one, clk_en_two, clk_en_three}));
    chk("bus_en", 48'({e1, e2, e3}), 48'({bus_en_one, bus_en_two, bus_en_three}));
  endtask : lanes
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset;
    for (int r = 0; r < 3; r++) begin
      av_rd(6'(r * 4));
      chk("ctrl reset", 32'h0, rd);
    end
    lanes(msk[0], msk[1], msk[2]);
    $display("t_reset done");
  endtask : t_reset
  task t_bits;
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < 16; b++) begin
        av_wr(6'(r * 4), 16'h0001 << b, 4'hF);
        av_rd(6'(r * 4));
        chk("ctrl readback", 32'((16'h0001 << b) & msk[r]), rd);
        e = msk;
        e[r] = msk[r] & ~(16'h0001 << b);
        lanes(e[0], e[1], e[2]);
      end
      av_wr(6'(r * 4), 16'h0000, 4'hF);
    end
    $display("t_bits done");
  endtask : t_bits
  task t_all;
    for (int r = 0; r < 3; r++) begin
      av_wr(6'(r * 4), 16'hFFFF, 4'hF);
      av_rd(6'(r * 4));
      chk("ctrl full", 32'(msk[r]), rd);
    end
    lanes(16'h0000, 16'h0000, 16'h0000);
    for (int r = 0; r < 3; r++) av_wr(6'(r * 4), 16'h0000, 4'hF);
    lanes(msk[0], msk[1], msk[2]);
    $display("t_all done");
  endtask : t_all
  task t_delay;
    int n;
    for (int v = 1; v >= 0; v--) begin
      av_wr(6'h00, 16'(v), 4'hF);
      n = 0;
      do begin @(negedge clk_sys); n++; end while (clk_en_one[0] !== 1'(1 - v) && n < 10);
      // the write lands at the answer edge, the lane on one of the next PCG_INSTR_CYC edges
      chk("lane delay", 1, 32'(n >= 2 && n <= PCG_INSTR_CYC + 1));
    end
    $display("t_delay done");
  endtask : t_delay
  task t_misc;
    av_wr(6'h00, 16'hFFFF, 4'h1);
    av_rd(6'h00);
    chk("low lane only", 32'h000000FB, rd);
    av_wr(6'h00, 16'h0000, 4'hF);
    av_wr(6'h3C, 16'hFFFF, 4'hF);
    av_rd(6'h3C);
    chk("unmapped", 32'h0, rd);
    av_wr(6'h0C, 16'h0000, 4'hF);
    av_rd(6'h0C);
    chk("present", 32'(PCG_MASK_ONE), rd);
    av_rd(6'h18);
    chk("enabled lanes", 32'(PCG_MASK_ONE), rd);
    av_rd(6'h24);
    chk("divider", 32'(PCG_TICK_DIV_RST), rd);
    // divider zero: a tick every clock, so the lane turns one clock after the write lands
    av_wr(6'h24, 16'h0000, 4'hF);
    av_wr(6'h00, 16'h0001, 4'hF);
    @(negedge clk_sys);
    chk("fast tick hold", 1, clk_en_one[0]);
    @(negedge clk_sys);
    chk("fast tick off", 0, clk_en_one[0]);
    av_wr(6'h24, 16'(PCG_TICK_DIV_RST), 4'hF);
    av_wr(6'h00, 16'h0000, 4'hF);
    lanes(msk[0], msk[1], msk[2]);
    $display("t_misc done");
  endtask : t_misc
  task t_rerst;
    av_wr(6'h04, 16'hFFFF, 4'hF);
    lanes(msk[0], 16'h0000, msk[2]);
    srst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    av_rd(6'h04);
    chk("ctrl after reset", 32'h0, rd);
    lanes(msk[0], msk[1], msk[2]);
    $display("t_rerst done");
  endtask : t_rerst
  task close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    fail_count++;
    $display("[ERR] watchdog expected done seen hang");
    close_out;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset;
    t_bits;
    t_all;
    t_delay;
    t_misc;
    t_rerst;
    close_out;
  end
endmodule : pcg_peripheral_clock_gating_bench

// *** verif/pcg_peripheral_clock_gating_props.sv ***
// checker for the peripheral clock gating block, bound to its top module
`timescale 1ns/1ps
module pcg_peripheral_clock_gating_props
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [PCG_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // lanes
  input wire logic [15:0] clk_en_one,
  input wire logic [15:0] clk_en_two,
  input wire logic [15:0] clk_en_three,
  input wire logic [15:0] bus_en_one,
  input wire logic [15:0] bus_en_two,
  input wire logic [15:0] bus_en_three
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_ack_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_upper; !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000; endproperty
  property p_absent;
    ((clk_en_one & ~PCG_MASK_ONE) | (clk_en_two & ~PCG_MASK_TWO) | (clk_en_three & ~PCG_MASK_THREE)) == 16'h0000;
  endproperty
  property p_bus; {bus_en_one, bus_en_two, bus_en_three} == {clk_en_one, clk_en_two, clk_en_three}; endproperty
  sequence s_wr(logic [3:0] idx, logic [15:0] d);
    avs_write && avs_waitrequest && avs_address[5:2] == idx && avs_byteenable[1:0] == 2'b11
      && avs_writedata[15:0] == d;
  endsequence
  property p_off_one; s_wr(4'h0, 16'hFFFF) |-> ##[1:7] clk_en_one == 16'h0000; endproperty
  property p_on_one; s_wr(4'h0, 16'h0000) |-> ##[1:7] clk_en_one == PCG_MASK_ONE; endproperty
  property p_off_three; s_wr(4'h2, 16'hFFFF) |-> ##[1:7] clk_en_three == 16'h0000; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("waitrequest low too long");
  a_answer: assert property (p_answer) else $error("request not answered next cycle");
  a_upper: assert property (p_upper) else $error("upper read half not zero");
  a_absent: assert property (p_absent) else $error("absent lane enabled");
  a_bus: assert property (p_bus) else $error("bus enable differs from clock enable");
  a_off_one: assert property (p_off_one) else $error("first lanes not stopped in time");
  a_on_one: assert property (p_on_one) else $error("first lanes not restored in time");
  a_off_three: assert property (p_off_three) else $error("third lanes not stopped in time");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_write: cover property (avs_write && !avs_waitrequest);
  c_off: cover property (clk_en_one == 16'h0000);
endmodule : pcg_peripheral_clock_gating_props

bind pcg_peripheral_clock_gating pcg_peripheral_clock_gating_props u_props (.*);
